// ===== verilog/cpso_top.v
/* Configurable status-output pins of a USB-to-UART bridge: pin function
   mux, activity one-shots, charger and suspend indicators, line-driver
   enable, UART line inversion, suspend pull-down, remote wakeup and the
   configuration load after reset, with an APB register slave.
   Assumes a 200 MHz clock, inputs synchronous to it, and a UART core that
   flags the lead bit period and the frame itself.
//
// Contract
// - Charger detected while suspended asserts output
// - Pins offer active-high and active-low charger
// - Enumerated, not suspended: charger output inactive
// - Shorted data lines leave device suspended
// - Any pin takes one of three LEDs
// - Upstream LED shows UART-to-host data
// - Downstream LED shows host-to-UART data
// - Combined LED shows either direction
// - Active LED drives low, else high-impedance
// - One-shot stretches LED activity visibly
// - Reload configuration after every reset kind
// - Optional suspend pull-down, default off
// - Ring low while suspended wakes host
// - Suspend indicator low while suspended
// - Default pins: driver, down, up, suspend
// - TXD, RXD, RTS inversion, default off
// - Report USB version 0200, full speed
// - Serial number enabled, factory value
// - Max power 90mA, bus powered default
// - Driver-select flag enabled by default
// - Driver enable: lead bit to stop bit
// - CTS, DTR, DSR, DCD, ring inversion
*/
`timescale 1ns/1ps
`include "cpso_map.vh"
module cpso_top #(
   parameter integer WAKE_CYC = `CPSO_WAKE_MS * `CPSO_CLK_KHZ,
   parameter integer LED_CYC  = `CPSO_LED_MS * `CPSO_CLK_KHZ,
   parameter [31:0]  SERIAL   = 32'h1234ABCD  // Arbitrary factory serial
) (
   // Clock and reset
   input  wire        clk,
   input  wire        reset,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // USB core status
   input  wire        usb_suspend,
   input  wire        usb_bus_reset,
   input  wire        charge_port_detect,
   output reg         remote_wake_q,
   // UART core side
   input  wire        core_txd,
   input  wire        core_rts_n,
   input  wire        core_dtr_n,
   input  wire        tx_lead,
   input  wire        tx_frame,
   input  wire        up_byte,
   input  wire        down_byte,
   output reg         core_rxd_q,
   output reg         core_cts_n_q,
   output reg         core_dsr_n_q,
   output reg         core_dcd_n_q,
   output reg         core_ring_n_q,
   // UART pins
   input  wire        rxd_pin,
   input  wire        cts_n_pin,
   input  wire        dsr_n_pin,
   input  wire        carrier_detect_n,
   input  wire        ring_indicate_n,
   output reg         txd_pin_q,
   output reg         rts_n_pin_q,
   output reg         dtr_n_pin_q,
   output reg         uart_pull_down_q,
   // Configurable pins
   output reg  [3:0]  config_io_pin_o_q,
   output reg  [3:0]  config_io_pin_oe_q,
   // Descriptor values
   output reg  [15:0] desc_usb_version_q,
   output reg  [7:0]  desc_max_power_q,
   output reg         desc_self_powered_q,
   output reg         desc_serial_en_q,
   output reg  [31:0] desc_serial_q,
   output reg         serial_port_driver_select,
   output reg         load_done_q
);
   // ****************************************
   // Declarations
   // ****************************************
   reg  [15:0] pinfunc_q;          // Stored configuration
   reg  [12:0] options_q;
   reg  [15:0] usb_ver_q;
   reg  [9:0]  max_ma_q;
   reg  [31:0] serial_q;
   reg  [15:0] act_pinfunc_q;      // Active copy, loaded at scan
   reg  [12:0] act_opt_q;
   reg  [4:0]  load_cnt_q;
   reg         load_busy_q;
   reg         reload_q;
   reg  [31:0] up_cnt_q;
   reg  [31:0] down_cnt_q;
   reg  [31:0] wake_cnt_q;
   reg         wake_armed_q;
   reg         charger_q;
   reg         drv_en_q;
   wire        wr_en;
   wire        rd_ok;
   wire        up_act;
   wire        down_act;
   wire        ring_act;
   wire        susp_pd;

   // Decode a 4-bit function code into pin level and enable {oe, out}
   function [1:0] pin_drive;
      input [3:0] fn;
      input       drv;
      input       up;
      input       down;
      input       susp;
      input       chg;
      begin
         case (fn)
            `CPSO_FN_DRV_EN:     pin_drive = {1'b1, drv};
            `CPSO_FN_DOWN_LED:   pin_drive = {down, 1'b0};
            `CPSO_FN_UP_LED:     pin_drive = {up, 1'b0};
            `CPSO_FN_COMB_LED:   pin_drive = {up | down, 1'b0};
            `CPSO_FN_SUSPEND_N:  pin_drive = {1'b1, ~susp};
            `CPSO_FN_CHARGER:    pin_drive = {1'b1, chg};
            `CPSO_FN_CHARGER_N:  pin_drive = {1'b1, ~chg};
            `CPSO_FN_POWER_EN_N: pin_drive = {1'b1, susp};
            default:             pin_drive = 2'b00;
         endcase
      end
   endfunction

   // ****************************************
   // APB slave
   // ****************************************
   // One wait state keeps prdata and pready straight from flops
   assign wr_en = psel & penable & pready & pwrite;
   assign rd_ok = (paddr == `CPSO_OFS_PINFUNC) | (paddr == `CPSO_OFS_OPTIONS) |
                  (paddr == `CPSO_OFS_DESC) | (paddr == `CPSO_OFS_SERIAL) |
                  (paddr == `CPSO_OFS_STATUS) | (paddr == `CPSO_OFS_CONTROL);

   // Handshake, read data and error answer
   always @(posedge clk) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~rd_ok;
         prdata  <= 32'h0000_0000;
         if (psel & penable & ~pready & ~pwrite) begin
            case (paddr)
               `CPSO_OFS_PINFUNC: prdata <= {16'h0000, pinfunc_q};
               `CPSO_OFS_OPTIONS: prdata <= {19'h00000, options_q};
               `CPSO_OFS_DESC:    prdata <= {usb_ver_q, 6'h00, max_ma_q};
               `CPSO_OFS_SERIAL:  prdata <= serial_q;
               `CPSO_OFS_STATUS:  prdata <= {25'h0000000, remote_wake_q,
                                     drv_en_q, charger_q, down_act, up_act,
                                     usb_suspend, load_done_q};
               default:           prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Stored configuration; it survives a USB reset like real memory does
   always @(posedge clk) begin
      if (reset) begin
         pinfunc_q <= `CPSO_RST_PINFUNC;
         options_q <= `CPSO_RST_OPTIONS;
         usb_ver_q <= `CPSO_RST_USB_VER;
         max_ma_q  <= `CPSO_RST_MAX_MA;
         serial_q  <= SERIAL;
         reload_q  <= 1'b0;
      end else begin
         reload_q <= wr_en & (paddr == `CPSO_OFS_CONTROL) & pwdata[0];
         if (wr_en) begin
            case (paddr)
               `CPSO_OFS_PINFUNC: pinfunc_q <= pwdata[15:0];
               `CPSO_OFS_OPTIONS: options_q <= pwdata[12:0];
               `CPSO_OFS_DESC: begin
                  usb_ver_q <= pwdata[31:16];
                  max_ma_q  <= pwdata[9:0];
               end
               `CPSO_OFS_SERIAL:  serial_q <= pwdata;
               default:           ;
            endcase
         end
      end
   end

   // ****************************************
   // Configuration load
   // ****************************************
   // A scan of fixed length copies stored fields into the active set;
   // pins stay released until it ends
   always @(posedge clk) begin
      if (reset) begin
         load_busy_q <= 1'b1;
         load_cnt_q  <= 5'd0;
         load_done_q <= 1'b0;
      end else if (usb_bus_reset | reload_q) begin
         load_busy_q <= 1'b1;
         load_cnt_q  <= 5'd0;
         load_done_q <= 1'b0;
      end else if (load_busy_q) begin
         load_cnt_q <= load_cnt_q + 5'd1;
         if (load_cnt_q == `CPSO_LOAD_CYC - 1) begin
            load_busy_q <= 1'b0;
            load_done_q <= 1'b1;
         end
      end
   end

   // Active copy and descriptor values, taken at the end of the scan
   always @(posedge clk) begin
      if (reset) begin
         act_pinfunc_q             <= 16'h0000;
         act_opt_q                 <= 13'h0000;
         desc_usb_version_q        <= 16'h0000;
         desc_max_power_q          <= 8'h00;
         desc_self_powered_q       <= 1'b0;
         desc_serial_en_q          <= 1'b0;
         desc_serial_q             <= 32'h0000_0000;
         serial_port_driver_select <= 1'b0;
      end else if (load_busy_q && load_cnt_q == `CPSO_LOAD_CYC - 1) begin
         act_pinfunc_q             <= pinfunc_q;
         act_opt_q                 <= options_q;
         desc_usb_version_q        <= usb_ver_q;
         desc_max_power_q          <= max_ma_q[8:1];
         desc_self_powered_q       <= options_q[`CPSO_OPT_SELFPWR];
         desc_serial_en_q          <= options_q[`CPSO_OPT_SERIAL];
         desc_serial_q             <= serial_q;
         serial_port_driver_select <= options_q[`CPSO_OPT_DRVSEL];
      end
   end

   // ****************************************
   // Activity one-shots
   // ****************************************
   assign up_act   = (up_cnt_q != 32'd0);
   assign down_act = (down_cnt_q != 32'd0);

   // Each byte reloads its counter, so sparse traffic still blinks
   always @(posedge clk) begin
      if (reset) begin
         up_cnt_q   <= 32'd0;
         down_cnt_q <= 32'd0;
      end else begin
         if (up_byte)
            up_cnt_q <= LED_CYC;
         else if (up_act)
            up_cnt_q <= up_cnt_q - 32'd1;
         if (down_byte)
            down_cnt_q <= LED_CYC;
         else if (down_act)
            down_cnt_q <= down_cnt_q - 32'd1;
      end
   end

   // ****************************************
   // Charger, driver enable, remote wakeup
   // ****************************************
   // Charge port shorts the data lines, so the USB core stays suspended;
   // the flag drops as soon as the device leaves suspend
   always @(posedge clk) begin
      if (reset) begin
         charger_q <= 1'b0;
         drv_en_q  <= 1'b0;
      end else begin
         if (!usb_suspend)
            charger_q <= 1'b0;
         else if (charge_port_detect)
            charger_q <= 1'b1;
         drv_en_q <= tx_lead | tx_frame;
      end
   end

   assign ring_act = ring_indicate_n ^ ~act_opt_q[`CPSO_OPT_INV_RING];

   // One wake burst per ring assertion, only while suspended
   always @(posedge clk) begin
      if (reset) begin
         wake_cnt_q    <= 32'd0;
         wake_armed_q  <= 1'b1;
         remote_wake_q <= 1'b0;
      end else begin
         if (!ring_act)
            wake_armed_q <= 1'b1;
         if (wake_cnt_q != 32'd0) begin
            wake_cnt_q    <= wake_cnt_q - 32'd1;
            remote_wake_q <= (wake_cnt_q != 32'd1);
         end else if (usb_suspend && ring_act && wake_armed_q && load_done_q &&
                      act_opt_q[`CPSO_OPT_WAKE]) begin
            wake_cnt_q    <= WAKE_CYC;
            wake_armed_q  <= 1'b0;
            remote_wake_q <= 1'b1;
         end
      end
   end

   // ****************************************
   // UART lines: inversion and suspend pull-down
   // ****************************************
   assign susp_pd = usb_suspend & act_opt_q[`CPSO_OPT_PULLDOWN];

   // Pulled-down outputs go low so the idle lines draw no current
   always @(posedge clk) begin
      if (reset) begin
         txd_pin_q        <= 1'b1;
         rts_n_pin_q      <= 1'b1;
         dtr_n_pin_q      <= 1'b1;
         uart_pull_down_q <= 1'b0;
         core_rxd_q       <= 1'b1;
         core_cts_n_q     <= 1'b1;
         core_dsr_n_q     <= 1'b1;
         core_dcd_n_q     <= 1'b1;
         core_ring_n_q    <= 1'b1;
      end else begin
         uart_pull_down_q <= susp_pd;
         txd_pin_q   <= ~susp_pd & (core_txd ^ act_opt_q[`CPSO_OPT_INV_TXD]);
         rts_n_pin_q <= ~susp_pd & (core_rts_n ^ act_opt_q[`CPSO_OPT_INV_RTS]);
         dtr_n_pin_q <= ~susp_pd & (core_dtr_n ^ act_opt_q[`CPSO_OPT_INV_DTR]);
         core_rxd_q    <= rxd_pin ^ act_opt_q[`CPSO_OPT_INV_RXD];
         core_cts_n_q  <= cts_n_pin ^ act_opt_q[`CPSO_OPT_INV_CTS];
         core_dsr_n_q  <= dsr_n_pin ^ act_opt_q[`CPSO_OPT_INV_DSR];
         core_dcd_n_q  <= carrier_detect_n ^ act_opt_q[`CPSO_OPT_INV_DCD];
         core_ring_n_q <= ~ring_act;
      end
   end

   // ****************************************
   // Configurable pin mux
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
         wire [1:0] drive;
         // Function chosen from the active copy; LEDs only pull low
         assign drive = pin_drive(act_pinfunc_q[4*gi+3:4*gi], drv_en_q,
                                  up_act, down_act, usb_suspend, charger_q);
         always @(posedge clk) begin
            if (reset) begin
               config_io_pin_o_q[gi]  <= 1'b0;
               config_io_pin_oe_q[gi] <= 1'b0;
            end else begin
               config_io_pin_o_q[gi]  <= drive[0];
               config_io_pin_oe_q[gi] <= drive[1] & load_done_q;
            end
         end
      end
   endgenerate

endmodule // cpso_top

// ===== verilog/cpso_map.vh
/* Constants of the configurable status-output pin block: register
   offsets, field positions, reset values, pin function codes and timing.
   Assumes inclusion by bare name from the design file. */
`ifndef CPSO_MAP_VH
`define CPSO_MAP_VH
// ****************************************
// Register byte offsets (APB, 32-bit words)
// ****************************************
`define CPSO_OFS_PINFUNC   8'h00
`define CPSO_OFS_OPTIONS   8'h04
`define CPSO_OFS_DESC      8'h08
`define CPSO_OFS_SERIAL    8'h0C
`define CPSO_OFS_STATUS    8'h10
`define CPSO_OFS_CONTROL   8'h14
// ****************************************
// Option register bits
// ****************************************
`define CPSO_OPT_INV_TXD   0
`define CPSO_OPT_INV_RXD   1
`define CPSO_OPT_INV_RTS   2
`define CPSO_OPT_INV_CTS   3
`define CPSO_OPT_INV_DTR   4
`define CPSO_OPT_INV_DSR   5
`define CPSO_OPT_INV_DCD   6
`define CPSO_OPT_INV_RING  7
`define CPSO_OPT_PULLDOWN  8
`define CPSO_OPT_WAKE      9
`define CPSO_OPT_SERIAL    10
`define CPSO_OPT_DRVSEL    11
`define CPSO_OPT_SELFPWR   12
// ****************************************
// Pin function codes (4 bits per pin)
// ****************************************
`define CPSO_FN_TRISTATE   4'h0
`define CPSO_FN_DRV_EN     4'h1
`define CPSO_FN_DOWN_LED   4'h3
`define CPSO_FN_UP_LED     4'h2
`define CPSO_FN_COMB_LED   4'h4
`define CPSO_FN_SUSPEND_N  4'h5
`define CPSO_FN_CHARGER    4'h6
`define CPSO_FN_CHARGER_N  4'h7
`define CPSO_FN_POWER_EN_N 4'h8
// ****************************************
// Reset values
// ****************************************
`define CPSO_RST_PINFUNC   16'h5231
`define CPSO_RST_OPTIONS   13'h0E00
`define CPSO_RST_USB_VER   16'h0200
`define CPSO_RST_MAX_MA    10'd90
// ****************************************
// Timing
// ****************************************
`define CPSO_CLK_KHZ       200000
`define CPSO_WAKE_MS       20
`define CPSO_LED_MS        5
`define CPSO_LOAD_CYC      16
`endif

// ===== dv/cpso_monitor.sv
/* Assertion checker for the status-output pin block; sees top ports only.
   Assumes pins 0..2 keep their default functions and no byte pulse
   lands within ten cycles of a rescan. */
`timescale 1ns/1ps
module cpso_monitor #(
   parameter integer WAKE_CYC = 20,
   parameter integer LED_CYC  = 10
) (
   // Clock and reset
   input wire       clk,
   input wire       reset,
   // Inputs of the block
   input wire       usb_suspend,
   input wire       ring_indicate_n,
   input wire       tx_lead,
   input wire       tx_frame,
   input wire       up_byte,
   input wire       down_byte,
   // Outputs of the block
   input wire       remote_wake_q,
   input wire       txd_pin_q,
   input wire       rts_n_pin_q,
   input wire       dtr_n_pin_q,
   input wire       uart_pull_down_q,
   input wire       load_done_q,
   input wire [3:0] config_io_pin_o_q,
   input wire [3:0] config_io_pin_oe_q
);
   // ****************************************
   // Helper counters
   // ****************************************
   reg [7:0]  idle_q;
   reg [31:0] wake_cnt_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Cycles since a downstream byte; saturates so it never wraps
   always @(posedge clk) begin
      if (reset || down_byte) idle_q <= 8'h00;
      else if (idle_q != 8'hFF) idle_q <= idle_q + 8'h01;
   end
   // Length of the running wake burst
   always @(posedge clk) begin
      if (reset || !remote_wake_q) wake_cnt_q <= 32'h0;
      else wake_cnt_q <= wake_cnt_q + 32'h1;
   end
   // ****************************************
   // Assertions
   // ****************************************
   a_load_time: assert property ($fell(reset) |-> !load_done_q [*8] ##[6:11] load_done_q)
      else $error("configuration load time wrong");
   a_pins_float: assert property (!load_done_q && !$past(load_done_q) |-> config_io_pin_oe_q == 4'h0)
      else $error("pin driven before load done");
   a_drv_follow: assert property (load_done_q && $past(load_done_q, 2) |-> config_io_pin_oe_q[0] &&
      config_io_pin_o_q[0] == ($past(tx_lead, 2) | $past(tx_frame, 2)))
      else $error("driver enable pin wrong");
   a_down_led: assert property (down_byte && load_done_q |-> ##2 (config_io_pin_oe_q[1] && !config_io_pin_o_q[1]) [*8])
      else $error("downstream led not stretched low");
   a_up_led: assert property (up_byte && load_done_q |-> ##2 (config_io_pin_oe_q[2] && !config_io_pin_o_q[2]) [*8])
      else $error("upstream led not stretched low");
   a_led_release: assert property (idle_q > LED_CYC + 4 |-> !config_io_pin_oe_q[1])
      else $error("downstream led not released");
   a_wake_cause: assert property ($rose(remote_wake_q) |-> !$past(ring_indicate_n) || !$past(ring_indicate_n, 2))
      else $error("wake without ring");
   a_wake_hold: assert property ($rose(remote_wake_q) |-> remote_wake_q [*8])
      else $error("wake burst too short");
   a_wake_max: assert property (wake_cnt_q <= WAKE_CYC)
      else $error("wake burst too long");
   a_pull_low: assert property (uart_pull_down_q && $past(uart_pull_down_q) |-> !txd_pin_q && !rts_n_pin_q && !dtr_n_pin_q)
      else $error("lines not pulled low");
   a_pull_awake: assert property (!usb_suspend [*3] |-> !uart_pull_down_q)
      else $error("pull-down while awake");
   // Main scenarios
   c_down_led: cover property (down_byte && load_done_q);
   c_wake: cover property ($rose(remote_wake_q));
   c_pull: cover property ($rose(uart_pull_down_q));
endmodule // cpso_monitor

// ===== dv/cpso_far_side.sv
/* Far side of the configurable pins: LEDs, charger and transceiver
   enables, each pin with a pull-up, so a released pin reads high.
   Assumes the pin driver outputs connect straight through. */
`timescale 1ns/1ps
module cpso_far_side (
   // Pin drivers of the block
   input  wire [3:0] pin_o,
   input  wire [3:0] pin_oe,
   // Resolved wire levels
   output wire [3:0] pin_level
);
   // A driven pin wins; a released one floats up through its pull-up
   assign pin_level = (pin_oe & pin_o) | ~pin_oe;
endmodule // cpso_far_side

// ===== dv/cpso_top_test.sv
/* Self-checking bench for the status-output pin block: APB master,
   UART and USB stimulus, far-side pin model and checks.
   Assumes cpso_monitor and cpso_far_side are compiled first. */
`timescale 1ns/1ps
`include "cpso_map.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module cpso_top_test;
   // ****************************************
   // Signals and instances
   // ****************************************
   localparam integer WAKE_CYC = 20;
   localparam integer LED_CYC  = 10;
   localparam [31:0]  SERIAL   = 32'h5EED0001;  // Arbitrary serial value
   reg         clk, reset, psel, penable, pwrite, usb_suspend, usb_bus_reset, charge_port_detect;
   reg         core_txd, core_rts_n, core_dtr_n, tx_lead, tx_frame, up_byte, down_byte;
   reg         rxd_pin, cts_n_pin, dsr_n_pin, carrier_detect_n, ring_indicate_n;
   reg  [7:0]  paddr, r, m;
   reg  [31:0] pwdata;
   wire [31:0] prdata, desc_serial_q;
   wire        pready, pslverr, remote_wake_q, core_rxd_q, core_cts_n_q, core_dsr_n_q, core_dcd_n_q;
   wire        core_ring_n_q, txd_pin_q, rts_n_pin_q, dtr_n_pin_q, uart_pull_down_q, load_done_q;
   wire        desc_self_powered_q, desc_serial_en_q, serial_port_driver_select;
   wire [3:0]  config_io_pin_o_q, config_io_pin_oe_q, pin_level;
   wire [15:0] desc_usb_version_q;
   wire [7:0]  desc_max_power_q;
   logic [33:0] exp_q[$];
   logic [33:0] e;
   int failures = 0, samples_checked = 0, cyc = 0, n;
   cpso_top #(.WAKE_CYC(WAKE_CYC), .LED_CYC(LED_CYC), .SERIAL(SERIAL)) u_cpso_top (
      .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .usb_suspend(usb_suspend),
      .usb_bus_reset(usb_bus_reset), .charge_port_detect(charge_port_detect), .remote_wake_q(remote_wake_q),
      .core_txd(core_txd), .core_rts_n(core_rts_n), .core_dtr_n(core_dtr_n), .tx_lead(tx_lead),
      .tx_frame(tx_frame), .up_byte(up_byte), .down_byte(down_byte), .core_rxd_q(core_rxd_q),
      .core_cts_n_q(core_cts_n_q), .core_dsr_n_q(core_dsr_n_q), .core_dcd_n_q(core_dcd_n_q),
      .core_ring_n_q(core_ring_n_q), .rxd_pin(rxd_pin), .cts_n_pin(cts_n_pin), .dsr_n_pin(dsr_n_pin),
      .carrier_detect_n(carrier_detect_n), .ring_indicate_n(ring_indicate_n), .txd_pin_q(txd_pin_q),
      .rts_n_pin_q(rts_n_pin_q), .dtr_n_pin_q(dtr_n_pin_q), .uart_pull_down_q(uart_pull_down_q),
      .config_io_pin_o_q(config_io_pin_o_q), .config_io_pin_oe_q(config_io_pin_oe_q),
      .desc_usb_version_q(desc_usb_version_q), .desc_max_power_q(desc_max_power_q),
      .desc_self_powered_q(desc_self_powered_q), .desc_serial_en_q(desc_serial_en_q),
      .desc_serial_q(desc_serial_q), .serial_port_driver_select(serial_port_driver_select),
      .load_done_q(load_done_q));
   cpso_far_side u_cpso_far_side (.pin_o(config_io_pin_o_q), .pin_oe(config_io_pin_oe_q), .pin_level(pin_level));
   // ****************************************
   // Clock, watcher, timeout and tasks
   // ****************************************
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   // Takes the oldest note at each completed transfer
   always @(posedge clk) begin
      if (pready === 1'h1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         `CHK(pslverr, e[32])
         if (e[33]) `CHK(prdata, e[31:0])
      end
   end
   // A hang ends the run as a failure
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         results();
      end
   end
   task automatic results;
      if (failures == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   // One APB transfer; for a read, d is the expected data
   task automatic apb(input bit wr, input [7:0] a, input [31:0] d, input bit err);
      exp_q.push_back({~wr, err, d});
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wait_load;
      tick(2);
      for (n = 0; n < 40 && load_done_q !== 1'h1; n++) @(posedge clk);
      tick(2);
   endtask
   // Stored settings only act after a rescan
   task automatic cfg(input [15:0] fn, input [12:0] op);
      apb(1'h1, `CPSO_OFS_PINFUNC, {16'h0, fn}, 1'h0);
      apb(1'h1, `CPSO_OFS_OPTIONS, {19'h0, op}, 1'h0);
      apb(1'h1, `CPSO_OFS_CONTROL, 32'h1, 1'h0);
      wait_load();
   endtask
   task automatic byte_pulse(input bit dn);
      @(posedge clk);
      down_byte <= dn;
      up_byte <= ~dn;
      @(posedge clk);
      down_byte <= 1'h0;
      up_byte <= 1'h0;
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = 43'h0;
      {usb_suspend, usb_bus_reset, charge_port_detect, tx_lead, tx_frame, up_byte, down_byte} = 7'h0;
      {core_txd, core_rts_n, core_dtr_n, rxd_pin, cts_n_pin, dsr_n_pin, carrier_detect_n, ring_indicate_n} = 8'hFF;
      reset = 1'h1;
      r = $urandom(37);
      tick(6);
      reset <= 1'h0;
      wait_load();
      apb(1'h0, `CPSO_OFS_PINFUNC, 32'h00005231, 1'h0);
      apb(1'h0, `CPSO_OFS_OPTIONS, 32'h00000E00, 1'h0);
      apb(1'h0, `CPSO_OFS_DESC, 32'h0200005A, 1'h0);
      apb(1'h0, `CPSO_OFS_SERIAL, SERIAL, 1'h0);
      apb(1'h0, 8'h18, 32'h0, 1'h1);
      apb(1'h0, `CPSO_OFS_STATUS, 32'h00000001, 1'h0);
      `CHK(desc_usb_version_q, 16'h0200)
      `CHK(desc_max_power_q, 8'h2D)
      `CHK({desc_self_powered_q, desc_serial_en_q, serial_port_driver_select}, 3'h3)
      `CHK(desc_serial_q, SERIAL)
      `CHK({config_io_pin_oe_q, pin_level}, 8'h9E)
      // LEDs, with a retrigger inside the stretch
      byte_pulse(1'h1);
      tick(3);
      `CHK(pin_level[2:1], 2'h2)
      tick(3);
      byte_pulse(1'h1);
      tick(8);
      `CHK(pin_level[1], 1'h0)
      tick(8);
      `CHK(pin_level[2:1], 2'h3)
      byte_pulse(1'h0);
      tick(3);
      `CHK(pin_level[2:1], 2'h1)
      tick(14);
      // Driver enable spans the lead bit and the frame
      tx_lead <= 1'h1;
      tick(4);
      `CHK(pin_level[0], 1'h1)
      tx_lead <= 1'h0;
      tx_frame <= 1'h1;
      tick(4);
      `CHK(pin_level[0], 1'h1)
      tx_frame <= 1'h0;
      tick(4);
      `CHK(pin_level[0], 1'h0)
      // Each inversion option alone, then none
      for (int b = 0; b < 9; b++) begin
         m = (b < 8) ? (8'h01 << b) : 8'h00;
         cfg(16'h5231, 13'h0E00 | {5'h00, m});
         r = $urandom;
         {ring_indicate_n, carrier_detect_n, dsr_n_pin, core_dtr_n, cts_n_pin, core_rts_n, rxd_pin, core_txd} <= r;
         tick(4);
         `CHK({core_ring_n_q, core_dcd_n_q, core_dsr_n_q, dtr_n_pin_q, core_cts_n_q, rts_n_pin_q, core_rxd_q, txd_pin_q}, r ^ m)
      end
      // Suspend, then remote wake by ring
      ring_indicate_n <= 1'h1;
      usb_suspend <= 1'h1;
      tick(4);
      `CHK({pin_level[3], uart_pull_down_q}, 2'h0)
      ring_indicate_n <= 1'h0;
      for (n = 0; n < 10 && remote_wake_q !== 1'h1; n++) @(posedge clk);
      for (n = 0; n < 40 && remote_wake_q === 1'h1; n++) @(posedge clk);
      `CHK((n >= WAKE_CYC - 1 && n <= WAKE_CYC), 1'h1)
      ring_indicate_n <= 1'h1;
      cfg(16'h5231, 13'h0F00);
      tick(2);
      `CHK({uart_pull_down_q, txd_pin_q, rts_n_pin_q, dtr_n_pin_q}, 4'h8)
      // Pin 3 as combined LED, then both charger polarities
      usb_suspend <= 1'h0;
      cfg(16'h4231, 13'h0E00);
      byte_pulse(1'h0);
      tick(3);
      `CHK(pin_level[3], 1'h0)
      tick(14);
      byte_pulse(1'h1);
      tick(3);
      `CHK(pin_level[3], 1'h0)
      tick(14);
      charge_port_detect <= 1'h1;
      for (int k = 0; k < 2; k++) begin
         cfg({4'h6 + k[3:0], 12'h231}, 13'h0E00);
         usb_suspend <= 1'h1;
         tick(4);
         `CHK(pin_level[3], ~k[0])
         usb_suspend <= 1'h0;
         tick(4);
         `CHK(pin_level[3], k[0])
      end
      // Bus reset releases the pins and reloads
      usb_bus_reset <= 1'h1;
      tick(1);
      usb_bus_reset <= 1'h0;
      tick(2);
      `CHK({load_done_q, config_io_pin_oe_q}, 5'h00)
      wait_load();
      `CHK({load_done_q, config_io_pin_oe_q}, 5'h19)
      results();
   end
endmodule // cpso_top_test
bind cpso_top cpso_monitor #(.WAKE_CYC(WAKE_CYC), .LED_CYC(LED_CYC)) u_cpso_monitor (
   .clk(clk), .reset(reset), .usb_suspend(usb_suspend), .ring_indicate_n(ring_indicate_n),
   .tx_lead(tx_lead), .tx_frame(tx_frame), .up_byte(up_byte), .down_byte(down_byte),
   .remote_wake_q(remote_wake_q), .txd_pin_q(txd_pin_q), .rts_n_pin_q(rts_n_pin_q),
   .dtr_n_pin_q(dtr_n_pin_q), .uart_pull_down_q(uart_pull_down_q), .load_done_q(load_done_q),
   .config_io_pin_o_q(config_io_pin_o_q), .config_io_pin_oe_q(config_io_pin_oe_q));
